// ---- hw/regulator_status_and_interrupt_masks.sv ----
// Regulator live status and event mask registers behind a two-wire serial slave port.
// Assumes analog status levels arrive asynchronously and event pulses come from logic on mclk.
`timescale 1ns/1ps

module regulator_status_and_interrupt_masks
    import regulator_regs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = DEFAULT_DEVICE_ADDR
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire linreg_raw_t linreg_raw,
    input  wire logic        otp_reset_reg_suppress,
    input  wire event_vec_t  event_in,
    output event_vec_t       event_flag_set,
    output event_vec_t       event_suppress,
    output logic             irq_pulse
);

    typedef struct packed {
        link_state_t state;
        logic [3:0]  cnt;
        logic [7:0]  shift;
        logic [7:0]  ptr;
        logic        have_ptr;
        logic        rd_mode;
        logic        acked;
        logic        drive;
        logic        scl_prev;
        logic        sda_prev;
        logic [7:0]  mask_a;
        logic [6:0]  mask_b_upper;
        logic        reset_reg_supp;
        logic        otp_loaded;
        logic [7:0]  sw_mask;
        event_vec_t  flags;
        logic        irq;
    } bank_state_t;

    bank_state_t st_reg;
    bank_state_t st_next;
    linreg_raw_t linreg_sync;
    logic [1:0]  bus_sync;
    logic [7:0]  linreg_status;

    // ==================================================================
    // Input synchronisers
    // ==================================================================
    // Analog status levels are not on mclk, so each passes the filtered synchroniser.
    sync3 #(
        .WIDTH     ($bits(linreg_raw_t)),
        .RESET_VAL ('0)
    ) u_linreg_sync (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .async_in  (linreg_raw),
        .sync_out  (linreg_sync)
    );

    // The serial lines idle high, so the filter starts high and no false start is seen.
    sync3 #(
        .WIDTH     (2),
        .RESET_VAL (BUS_IDLE_LEVELS)
    ) u_bus_sync (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .async_in  ({scl_in, sda_in}),
        .sync_out  (bus_sync)
    );

    // ==================================================================
    // Register contents
    // ==================================================================
    // Live status is raw and unlatched; reserved bits read as zero.
    always_comb
    begin
        linreg_status                   = 8'h00;
        linreg_status[LINREG1_ON_BIT]   = linreg_sync.linreg1_on_flag;
        linreg_status[LINREG1_BAD_BIT]  = linreg_sync.linreg1_output_bad_flag;
        linreg_status[LINREG1_ILIM_BIT] = linreg_sync.linreg1_current_limit_flag;
        linreg_status[LINREG0_ON_BIT]   = linreg_sync.linreg0_on_flag;
        linreg_status[LINREG0_BAD_BIT]  = linreg_sync.linreg0_output_bad_flag;
        linreg_status[LINREG0_ILIM_BIT] = linreg_sync.linreg0_current_limit_flag;
    end

    // Read decode; unmapped offsets answer a defined zero byte.
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input bank_state_t s, input logic [7:0] stat);
        logic [7:0] v;
        v = UNMAPPED_READ_VALUE;
        case (addr)
            LINREG_STATUS_ADDR:       v = stat;
            GLOBAL_EVENT_MASK_A_ADDR: v = s.mask_a;
            GLOBAL_EVENT_MASK_B_ADDR: v = {s.mask_b_upper, s.reset_reg_supp};
            SWITCHER_EVENT_MASK_ADDR: v = s.sw_mask;
            default:                  v = UNMAPPED_READ_VALUE;
        endcase
        return v;
    endfunction

    // Maps the mask bits onto the event sources.
    function automatic event_vec_t suppress_of(input bank_state_t s);
        event_vec_t e;
        e.power_good         = s.mask_a[POWER_GOOD_SUPP_BIT];
        e.sync_clk           = s.mask_a[SYNC_CLK_SUPP_BIT];
        e.thermal_warning    = s.mask_a[THERMAL_SUPP_BIT];
        e.load_current_ready = s.mask_a[LOAD_READY_SUPP_BIT];
        e.reset_reg          = s.reset_reg_supp;
        e.sw1_pg_fall        = s.sw_mask[SW1_PG_FALL_SUPP_BIT];
        e.sw1_pg_rise        = s.sw_mask[SW1_PG_RISE_SUPP_BIT];
        e.sw1_current_limit  = s.sw_mask[SW1_ILIM_SUPP_BIT];
        e.sw0_pg_fall        = s.sw_mask[SW0_PG_FALL_SUPP_BIT];
        e.sw0_pg_rise        = s.sw_mask[SW0_PG_RISE_SUPP_BIT];
        e.sw0_current_limit  = s.sw_mask[SW0_ILIM_SUPP_BIT];
        return e;
    endfunction

    // ==================================================================
    // Next state: events, OTP load and serial slave
    // ==================================================================
    // Bits are sampled on filtered SCL rise and SDA is changed on filtered SCL fall.
    always_comb
    begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_seen;
        logic       stop_seen;
        logic [7:0] tx;
        scl_rise   = bus_sync[1] & ~st_reg.scl_prev;
        scl_fall   = ~bus_sync[1] & st_reg.scl_prev;
        start_seen = bus_sync[1] & st_reg.scl_prev & st_reg.sda_prev & ~bus_sync[0];
        stop_seen  = bus_sync[1] & st_reg.scl_prev & ~st_reg.sda_prev & bus_sync[0];
        tx         = read_reg(st_reg.ptr, st_reg, linreg_status);
        st_next          = st_reg;
        st_next.scl_prev = bus_sync[1];
        st_next.sda_prev = bus_sync[0];
        // Flags follow events whatever the mask; only the interrupt is gated.
        st_next.flags    = event_in;
        st_next.irq      = |(event_in & ~suppress_of(st_reg));
        // The register-reset mask comes from OTP right after reset release.
        if (!st_reg.otp_loaded)
        begin
            st_next.reset_reg_supp = otp_reset_reg_suppress;
            st_next.otp_loaded     = 1'b1;
        end
        if (stop_seen)
        begin
            st_next.state = LINK_IDLE;
            st_next.drive = 1'b0;
        end
        else if (start_seen)
        begin
            st_next.state    = LINK_ADDR;
            st_next.cnt      = 4'h0;
            st_next.have_ptr = 1'b0;
            st_next.drive    = 1'b0;
        end
        else
        begin
            case (st_reg.state)
                LINK_ADDR, LINK_WBYTE:
                begin
                    if (scl_rise)
                    begin
                        st_next.shift = {st_reg.shift[6:0], bus_sync[0]};
                        st_next.cnt   = st_reg.cnt + 4'h1;
                    end
                    else if (scl_fall && st_reg.cnt == BYTE_BITS)
                    begin
                        if (st_reg.state == LINK_ADDR)
                        begin
                            if (st_reg.shift[7:1] == DEVICE_ADDR)
                            begin
                                st_next.rd_mode = st_reg.shift[0];
                                st_next.drive   = 1'b1;
                                st_next.state   = LINK_ADDR_ACK;
                            end
                            else
                            begin
                                st_next.state = LINK_IDLE;
                            end
                        end
                        else
                        begin
                            st_next.drive = 1'b1;
                            st_next.state = LINK_WACK;
                            if (!st_reg.have_ptr)
                            begin
                                st_next.ptr      = st_reg.shift;
                                st_next.have_ptr = 1'b1;
                            end
                            else
                            begin
                                // Status is read-only and bit 0 of mask B ignores writes.
                                case (st_reg.ptr)
                                    GLOBAL_EVENT_MASK_A_ADDR: st_next.mask_a = st_reg.shift;
                                    GLOBAL_EVENT_MASK_B_ADDR: st_next.mask_b_upper = st_reg.shift[7:1];
                                    SWITCHER_EVENT_MASK_ADDR: st_next.sw_mask = st_reg.shift & SWITCHER_MASK_WRITABLE;
                                    default:                  st_next.ptr = st_reg.ptr;
                                endcase
                                st_next.ptr = st_reg.ptr + 8'h01;
                            end
                        end
                    end
                end
                LINK_ADDR_ACK, LINK_WACK:
                begin
                    if (scl_fall)
                    begin
                        st_next.cnt = 4'h0;
                        if (st_reg.state == LINK_ADDR_ACK && st_reg.rd_mode)
                        begin
                            st_next.shift = tx;
                            st_next.drive = ~tx[7];
                            st_next.cnt   = FIRST_BIT_SENT;
                            st_next.state = LINK_RDATA;
                        end
                        else
                        begin
                            st_next.drive = 1'b0;
                            st_next.state = LINK_WBYTE;
                        end
                    end
                end
                LINK_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (st_reg.cnt == BYTE_BITS)
                        begin
                            st_next.drive = 1'b0;
                            st_next.state = LINK_RACK;
                        end
                        else
                        begin
                            st_next.drive = ~st_reg.shift[6];
                            st_next.shift = {st_reg.shift[6:0], 1'b0};
                            st_next.cnt   = st_reg.cnt + 4'h1;
                        end
                    end
                end
                LINK_RACK:
                begin
                    if (scl_rise)
                    begin
                        st_next.acked = ~bus_sync[0];
                        if (!bus_sync[0])
                        begin
                            st_next.ptr = st_reg.ptr + 8'h01;
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (st_reg.acked)
                        begin
                            st_next.shift = tx;
                            st_next.drive = ~tx[7];
                            st_next.cnt   = FIRST_BIT_SENT;
                            st_next.state = LINK_RDATA;
                        end
                        else
                        begin
                            st_next.state = LINK_IDLE;
                        end
                    end
                end
                default:
                begin
                    st_next.state = LINK_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // State register
    // ==================================================================
    // Reset loads constants only; the OTP value is taken by the first clocked cycle after release.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg                <= '0;
            st_reg.state          <= LINK_IDLE;
            st_reg.scl_prev       <= 1'b1;
            st_reg.sda_prev       <= 1'b1;
            st_reg.mask_a         <= MASK_A_RESET;
            st_reg.mask_b_upper   <= MASK_B_UPPER_RESET;
            st_reg.reset_reg_supp <= RESET_REG_SUPP_RESET;
            st_reg.sw_mask        <= SWITCHER_MASK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Open drain: the pin is only ever pulled low, enable high while pulling.
    assign sda_out        = 1'b0;
    assign sda_oe         = st_reg.drive;
    assign event_flag_set = st_reg.flags;
    assign event_suppress = suppress_of(st_reg);
    assign irq_pulse      = st_reg.irq;

endmodule

// ---- hw/regulator_regs_pkg.sv ----
// Register map, field positions, reset values and carrier types of the regulator status and mask bank.
// Assumes a single 250 MHz clock domain and an open-drain two-wire serial port on the device pins.
package regulator_regs_pkg;

    // ==================================================================
    // Register offsets on the serial port
    // ==================================================================
    localparam logic [7:0] LINREG_STATUS_ADDR       = 8'h1F;
    localparam logic [7:0] GLOBAL_EVENT_MASK_A_ADDR = 8'h20;
    localparam logic [7:0] GLOBAL_EVENT_MASK_B_ADDR = 8'h21;
    localparam logic [7:0] SWITCHER_EVENT_MASK_ADDR = 8'h22;

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int LINREG1_ON_BIT        = 7;
    localparam int LINREG1_BAD_BIT       = 6;
    localparam int LINREG1_ILIM_BIT      = 4;
    localparam int LINREG0_ON_BIT        = 3;
    localparam int LINREG0_BAD_BIT       = 2;
    localparam int LINREG0_ILIM_BIT      = 0;
    localparam int POWER_GOOD_SUPP_BIT   = 7;
    localparam int SYNC_CLK_SUPP_BIT     = 4;
    localparam int THERMAL_SUPP_BIT      = 2;
    localparam int LOAD_READY_SUPP_BIT   = 0;
    localparam int RESET_REG_SUPP_BIT    = 0;
    localparam int SW1_PG_FALL_SUPP_BIT  = 7;
    localparam int SW1_PG_RISE_SUPP_BIT  = 6;
    localparam int SW1_ILIM_SUPP_BIT     = 4;
    localparam int SW0_PG_FALL_SUPP_BIT  = 3;
    localparam int SW0_PG_RISE_SUPP_BIT  = 2;
    localparam int SW0_ILIM_SUPP_BIT     = 0;

    // ==================================================================
    // Reset values and write masks
    // ==================================================================
    localparam logic [7:0] MASK_A_RESET          = 8'h90;
    localparam logic [6:0] MASK_B_UPPER_RESET    = 7'h00;
    localparam logic       RESET_REG_SUPP_RESET  = 1'b1;
    localparam logic [7:0] SWITCHER_MASK_RESET   = 8'hCC;
    localparam logic [7:0] SWITCHER_MASK_WRITABLE = 8'hDD;
    localparam logic [7:0] UNMAPPED_READ_VALUE   = 8'h00;

    // ==================================================================
    // Serial port constants
    // ==================================================================
    localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2A;
    localparam logic [3:0] BYTE_BITS           = 4'h8;
    localparam logic [3:0] FIRST_BIT_SENT      = 4'h1;
    localparam logic [1:0] BUS_IDLE_LEVELS     = 2'h3;

    // Raw live inputs from the two linear regulators.
    typedef struct packed {
        logic linreg1_on_flag;
        logic linreg1_output_bad_flag;
        logic linreg1_current_limit_flag;
        logic linreg0_on_flag;
        logic linreg0_output_bad_flag;
        logic linreg0_current_limit_flag;
    } linreg_raw_t;

    // One bit per maskable event source.
    typedef struct packed {
        logic power_good;
        logic sync_clk;
        logic thermal_warning;
        logic load_current_ready;
        logic reset_reg;
        logic sw1_pg_fall;
        logic sw1_pg_rise;
        logic sw1_current_limit;
        logic sw0_pg_fall;
        logic sw0_pg_rise;
        logic sw0_current_limit;
    } event_vec_t;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_ADDR_ACK,
        LINK_WBYTE,
        LINK_WACK,
        LINK_RDATA,
        LINK_RACK
    } link_state_t;

endpackage

// ---- hw/sync3.sv ----
// Three-stage synchroniser with agreement filter for levels from outside the clock domain.
// Assumes the inputs are slow levels; a change is accepted once stages two and three agree.
`timescale 1ns/1ps

module sync3 #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] held;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // ==================================================================
    // Next state
    // ==================================================================
    // The first stage feeds only the second, so a metastable sample never reaches logic.
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.held[i] = st_reg.s3[i];
            end
        end
    end

    // Registers reset to the idle level of the line.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.held;

endmodule

// ---- verification/regulator_masks_asserts.sv ----
// Checker for the regulator mask bank: event streams, interrupt gating and mask reset values.
// Assumes the single mclk domain with rst_b asynchronous and active low.
`timescale 1ns/1ps

module regulator_masks_asserts
    import regulator_regs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire linreg_raw_t linreg_raw,
    input wire logic        otp_reset_reg_suppress,
    input wire event_vec_t  event_in,
    input wire event_vec_t  event_flag_set,
    input wire event_vec_t  event_suppress,
    input wire logic        irq_pulse
);
    // ==================================================================
    // Properties
    // ==================================================================
    // Reset values are checked on the first edge that sees reset released, before any write can land.
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_FLAG_FOLLOWS: assert property ($past(rst_b) |-> event_flag_set == $past(event_in))
        else $error("event set stream does not follow the event inputs");
    AST_IRQ_GATED: assert property ($past(rst_b) |-> irq_pulse == |($past(event_in) & ~$past(event_suppress)))
        else $error("interrupt request does not match the unsuppressed events");
    AST_PG_RESET: assert property ($rose(rst_b) |-> event_suppress.power_good)
        else $error("power good suppress not set after reset");
    AST_SYNC_RESET: assert property ($rose(rst_b) |-> event_suppress.sync_clk)
        else $error("clock detect suppress not set after reset");
    AST_THERMAL_RESET: assert property ($rose(rst_b) |-> !event_suppress.thermal_warning)
        else $error("thermal suppress not clear after reset");
    AST_LOAD_RESET: assert property ($rose(rst_b) |-> !event_suppress.load_current_ready)
        else $error("load ready suppress not clear after reset");
    AST_RREG_RESET: assert property ($rose(rst_b) |-> event_suppress.reset_reg)
        else $error("reset suppress not set after reset");
    AST_OTP_LOAD: assert property ($rose(rst_b) |=> event_suppress.reset_reg == $past(otp_reset_reg_suppress))
        else $error("register reset suppress did not take the OTP value");
    AST_OTP_HOLD: assert property ($past(rst_b, 2) |-> $stable(event_suppress.reset_reg))
        else $error("register reset suppress changed outside reset");
    AST_SW_PG_RESET: assert property ($rose(rst_b) |-> event_suppress.sw1_pg_fall && event_suppress.sw1_pg_rise
        && event_suppress.sw0_pg_fall && event_suppress.sw0_pg_rise)
        else $error("switcher power good suppress bits not set after reset");
    AST_SW_ILIM_RESET: assert property ($rose(rst_b) |->
        {event_suppress.sw1_current_limit, event_suppress.sw0_current_limit} == 2'h0)
        else $error("switcher current limit suppress bits not clear after reset");
endmodule

bind regulator_status_and_interrupt_masks regulator_masks_asserts regulator_masks_asserts_i (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .linreg_raw(linreg_raw), .otp_reset_reg_suppress(otp_reset_reg_suppress), .event_in(event_in),
    .event_flag_set(event_flag_set), .event_suppress(event_suppress), .irq_pulse(irq_pulse));

// ---- verification/serial_host_model.sv ----
// Two-wire serial host: drives the clock line and pulls the data line low, open drain.
// Assumes the bench resolves the data wire from both pull-downs and a pull-up.
`timescale 1ns/1ps

module serial_host_model
    import regulator_regs_pkg::*;
#(
    parameter int HALF = 12
) (
    input  wire logic mclk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    // ==================================================================
    // Bus primitives
    // ==================================================================
    // Both lines idle released; the clock stands still high outside frames.
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Data moves three cycles after the clock fall so the device never sees it race the clock edge.
    task automatic bit_io(input logic b, output logic r);
        repeat (3) @(posedge mclk);
        sda_pull <= !b;
        repeat (HALF) @(posedge mclk);
        scl <= 1'b1;
        repeat (HALF) @(posedge mclk);
        r = sda_wire;
        scl <= 1'b0;
    endtask

    // Start when stop is 0, stop otherwise; data changes while the clock is high.
    task automatic edge_cond(input logic stop);
        repeat (3) @(posedge mclk);
        sda_pull <= stop;
        repeat (HALF) @(posedge mclk);
        scl <= 1'b1;
        repeat (HALF) @(posedge mclk);
        sda_pull <= !stop;
        repeat (HALF) @(posedge mclk);
        if (!stop) scl <= 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic nack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, nack);
    endtask

    // One register write, or a pointer write then repeated start and a single read ended by NACK.
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd, input logic [7:0] wd,
                        output logic [7:0] q, output logic nack);
        logic [7:0] j;
        logic       a0;
        logic       a1;
        logic       a2;
        q = 8'h00;
        edge_cond(1'b0);
        byte_io({dev, 1'b0}, 1'b1, j, a0);
        byte_io(ptr, 1'b1, j, a1);
        if (rd)
        begin
            edge_cond(1'b0);
            byte_io({dev, 1'b1}, 1'b1, j, a2);
            byte_io(8'hFF, 1'b1, q, j[0]);
        end
        else
            byte_io(wd, 1'b1, j, a2);
        edge_cond(1'b1);
        nack = a0 | a1 | a2;
    endtask
endmodule

// ---- verification/test_regulator_status_and_interrupt_masks.sv ----
// Self-checking bench for the regulator status and mask bank behind the serial port.
// Assumes the serial host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module test_regulator_status_and_interrupt_masks
    import regulator_regs_pkg::*;
;
    typedef struct packed { logic [7:0] ptr; logic wr; logic [7:0] wd; logic [7:0] exp; } row_t;

    logic        mclk, rst_b, otp_reset_reg_suppress, scl, sda_pull, sda_out, sda_oe, irq_pulse, nack;
    wire         sda_wire;
    logic [7:0]  q;
    linreg_raw_t linreg_raw;
    event_vec_t  event_in, event_flag_set, event_suppress;
    int          n_errors = 0;
    int          tests_run = 0;
    logic [5:0]  raws [2] = '{6'h35, 6'h0A};
    row_t        rows [9] = '{
        '{8'h1F, 1'b0, 8'h00, 8'h00},
        '{8'h20, 1'b0, 8'h00, 8'h90},
        '{8'h21, 1'b0, 8'h00, 8'h00},
        '{8'h22, 1'b0, 8'h00, 8'hCC},
        '{8'h20, 1'b1, 8'hFF, 8'hFF},
        '{8'h21, 1'b1, 8'hFF, 8'hFE},
        '{8'h22, 1'b1, 8'hFF, 8'hDD},
        '{8'h1F, 1'b1, 8'hFF, 8'h00},
        '{8'h35, 1'b1, 8'h5A, 8'h00}};

    // ==================================================================
    // Wiring
    // ==================================================================
    // Open-drain data line with pull-up: low when either party pulls.
    assign sda_wire = !(sda_pull || (sda_oe && !sda_out));

    regulator_status_and_interrupt_masks regulator_status_and_interrupt_masks_i (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .linreg_raw(linreg_raw), .otp_reset_reg_suppress(otp_reset_reg_suppress), .event_in(event_in),
        .event_flag_set(event_flag_set), .event_suppress(event_suppress), .irq_pulse(irq_pulse));

    serial_host_model serial_host_model_i (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

    // ==================================================================
    // Helpers
    // ==================================================================
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
        serial_host_model_i.xfer(DEFAULT_DEVICE_ADDR, ptr, 1'b1, 8'h00, v, nack);
    endtask

    // One-cycle event burst; set stream and gated request are both due on the next edge.
    task automatic pulse(input event_vec_t v, input logic exp_irq);
        @(posedge mclk) event_in <= v;
        @(posedge mclk) event_in <= '0;
        #1;
        check(event_flag_set, v);
        check({10'h0, irq_pulse}, {10'h0, exp_irq});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // A hung bus handshake would otherwise stall the run forever.
    initial
    begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        stop_test();
    end

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial
    begin
        rst_b = 1'b0;
        otp_reset_reg_suppress = 1'b0;
        linreg_raw = '0;
        event_in = '0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        foreach (rows[i])
        begin
            if (rows[i].wr) serial_host_model_i.xfer(DEFAULT_DEVICE_ADDR, rows[i].ptr, 1'b0, rows[i].wd, q, nack);
            rd(rows[i].ptr, q);
            check({3'h0, q}, {3'h0, rows[i].exp});
        end
        check(event_suppress, 11'h7BF);
        // Everything but the register-reset event is suppressed now.
        pulse(11'h7BF, 1'b0);
        pulse(11'h040, 1'b1);
        serial_host_model_i.xfer(DEFAULT_DEVICE_ADDR, 8'h20, 1'b0, 8'h00, q, nack);
        pulse(11'h400, 1'b1);
        pulse(11'h100, 1'b1);
        pulse(11'h008, 1'b0);
        foreach (raws[i])
        begin
            @(posedge mclk) linreg_raw <= raws[i];
            rd(8'h1F, q);
            check({3'h0, q}, {3'h0, raws[i][5:4], 1'b0, raws[i][3:1], 1'b0, raws[i][0]});
        end
        // A foreign device address is left unanswered and must not store.
        serial_host_model_i.xfer(DEFAULT_DEVICE_ADDR ^ 7'h01, 8'h20, 1'b0, 8'h55, q, nack);
        check({10'h0, nack}, 11'h001);
        rd(8'h20, q);
        check({3'h0, q}, 11'h000);
        // Second reset with the stored value now clear of its default.
        @(posedge mclk)
        begin
            rst_b <= 1'b0;
            otp_reset_reg_suppress <= 1'b1;
        end
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        check(event_suppress, 11'h676);
        rd(8'h21, q);
        check({3'h0, q}, 11'h001);
        rd(8'h22, q);
        check({3'h0, q}, 11'h0CC);
        stop_test();
    end
endmodule
